// ==== hdl/lane_alu.sv ====
// Purpose: four independent single-precision lanes for logic, move, min and max
// Assumes: operands already selected by register number
// Notes:   min/max return the second operand on any NaN or equal zeros
`timescale 1ns/100ps
`default_nettype none
module lane_alu
  import vec_pkg::*;
(
  lane_if.alu lp
);

  logic [LANES-1:0][FLAG_W-1:0] lane_flags;

  // ************************************************************
  // one datapath per lane, no carries between lanes
  // ************************************************************
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    logic [LANE_W-1:0] x;
    logic [LANE_W-1:0] y;
    logic [LANE_W-1:0] r;
    logic [FLAG_W-1:0] f;
    logic              x_lt;
    assign x = lp.a[i*LANE_W +: LANE_W];
    assign y = lp.b[i*LANE_W +: LANE_W];

    always_comb begin
      if (x[31] != y[31]) begin
        x_lt = x[31];
      end else if (x[31]) begin
        x_lt = x[30:0] > y[30:0];
      end else begin
        x_lt = x[30:0] < y[30:0];
      end
    end

    always_comb begin
      r = x;
      f = '0;
      unique case (lp.op)
        OP_AND:  r = x & y;
        OP_OR:   r = x | y;
        OP_XOR:  r = x ^ y;
        OP_ANDN: r = ~x & y;
        OP_MOV:  r = y;
        OP_MIN, OP_MAX: begin
          if (is_nan(x) || is_nan(y)) begin
            r = y;
            f[FLAG_INVALID] = 1'b1;
          end else if (is_zero(x) && is_zero(y)) begin
            r = y;
          end else if (lp.op == OP_MIN) begin
            r = x_lt ? x : y;
          end else begin
            r = x_lt ? y : x;
          end
          f[FLAG_DENORM] = is_denorm(x) || is_denorm(y);
          // flush keeps the sign; reports as underflow with inexact
          if (lp.ftz && is_denorm(r)) begin
            r = {r[31], 31'h0000_0000};
            f[FLAG_UNDER] = 1'b1;
            f[FLAG_PREC]  = 1'b1;
          end
        end
        default: r = x;
      endcase
    end

    assign lp.res[i*LANE_W +: LANE_W] = r;
    assign lane_flags[i]              = f;
  end

  // one event flag per type, or-ed over lanes, no per-lane reporting
  always_comb begin
    lp.flags = '0;
    for (int k = 0; k < LANES; k++) begin
      lp.flags = lp.flags | lane_flags[k];
    end
  end

endmodule : lane_alu
`default_nettype wire

// ==== hdl/lane_if.sv ====
// Purpose: carries operands, result and event flags between file and lane datapath
// Assumes: purely combinational path
// Notes:   flags are one bit per exception type, or-ed over all lanes
`timescale 1ns/100ps
`default_nettype none
interface lane_if;
  import vec_pkg::*;
  op_t                op;
  logic [VEC_W-1:0]   a;
  logic [VEC_W-1:0]   b;
  logic               ftz;
  logic [VEC_W-1:0]   res;
  logic [FLAG_W-1:0]  flags;
  modport ctl (output op, a, b, ftz, input res, flags);
  modport alu (input op, a, b, ftz, output res, flags);
endinterface : lane_if
`default_nettype wire

// ==== hdl/vec_pkg.sv ====
// Purpose: shared constants, types and helpers of the packed single vector register file
// Assumes: single clock, synchronous active-high reset
// Notes:   control/status field positions are shared by the file and its lane datapath
package vec_pkg;

  // ************************************************************
  // geometry
  // ************************************************************
  localparam int VEC_COUNT = 8;
  localparam int VEC_W     = 128;
  localparam int HALF_W    = 64;
  localparam int LANE_W    = 32;
  localparam int LANES     = 4;
  localparam int SEL_W     = 3;
  localparam int ADDR_W    = 32;

  // ************************************************************
  // control/status layout
  // ************************************************************
  localparam int CSR_W        = 32;
  localparam int FLAG_LSB     = 0;
  localparam int FLAG_W       = 6;
  localparam int MASK_LSB     = 7;
  localparam int MASK_W       = 6;
  localparam int RC_LSB       = 13;
  localparam int RC_W         = 2;
  localparam int FTZ_BIT      = 15;
  localparam int FLAG_INVALID = 0;
  localparam int FLAG_DENORM  = 1;
  localparam int FLAG_UNDER   = 4;
  localparam int FLAG_PREC    = 5;
  localparam logic [31:0] CSR_RESET = 32'h0000_1F80;
  // reserved bit 6 and bits 31:16 always read zero
  localparam logic [31:0] CSR_WMASK = 32'h0000_FFBF;

  // ************************************************************
  // prefetch
  // ************************************************************
  localparam int PF_MIN_BYTES  = 32;
  localparam int PF_ALIGN_BITS = $clog2(PF_MIN_BYTES);

  typedef enum logic [4:0] {
    OP_NOP, OP_LOAD_LO, OP_LOAD_HI, OP_LOAD_FULL,
    OP_STORE_LO, OP_STORE_HI, OP_STORE_FULL,
    OP_AND, OP_OR, OP_XOR, OP_ANDN, OP_MIN, OP_MAX, OP_MOV,
    OP_CSR_LOAD, OP_PREFETCH
  } op_t;

  function automatic logic is_nan(input logic [LANE_W-1:0] v);
    is_nan = (v[30:23] == 8'hFF) && (v[22:0] != 23'h00_0000);
  endfunction : is_nan

  function automatic logic is_denorm(input logic [LANE_W-1:0] v);
    is_denorm = (v[30:23] == 8'h00) && (v[22:0] != 23'h00_0000);
  endfunction : is_denorm

  function automatic logic is_zero(input logic [LANE_W-1:0] v);
    is_zero = (v[30:0] == 31'h0000_0000);
  endfunction : is_zero

endpackage : vec_pkg

// ==== hdl/vector_reg_file.sv ====
// Purpose: eight 128-bit packed single vector registers with control/status
// Assumes: ops arrive one per cycle from the execution core, qualified by op_valid and ce
// Notes:   results, store data and prefetch requests appear one cycle after the op
//
// Overview of operation
// - eight 128-bit vector registers, any one picked directly by number
// - vector registers carry data only; addresses come from integer registers
// - four 32-bit lanes, lane 0 in the lowest 32 bits
// - memory transfers move a 64-bit half or the full 128 bits
// - logic and arithmetic apply per lane, lanes independent
// - register file separate from legacy stack state; no emptying op needed
// - added packed-integer ops use legacy registers, never these
// - prefetch treats data as untyped, fetching at least 32 bytes
// - control/status holds masks, rounding, flush-to-zero and sticky flags
// - available identically in protected, real-address and virtual 8086 modes
// - lane arithmetic follows binary floating-point rules for single precision
// - flags bits 5-0 sticky, cleared only by written zero or reset
// - mask bits 12-7 mask when set; all set at reset
`timescale 1ns/100ps
`default_nettype none
module vector_reg_file
  import vec_pkg::*;
#(
  parameter int NUM_REGS = VEC_COUNT
)(
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                ce,
  input  wire logic                op_valid,
  input  wire op_t                 op,
  input  wire logic [SEL_W-1:0]    dst_sel,
  input  wire logic [SEL_W-1:0]    src_sel,
  input  wire logic [VEC_W-1:0]    mem_rdata,
  input  wire logic [CSR_W-1:0]    csr_wdata,
  input  wire logic [ADDR_W-1:0]   pf_addr_in,
  output logic [VEC_W-1:0]         result_data,
  output logic                     st_valid,
  output logic                     st_wide,
  output logic [VEC_W-1:0]         st_data,
  output logic                     pf_valid,
  output logic [ADDR_W-1:0]        pf_addr,
  output logic [CSR_W-1:0]         csr_value,
  output logic                     exc_req
);

  if (NUM_REGS != (1 << SEL_W)) begin : g_bad_regs
    $error("NUM_REGS must equal 2**SEL_W");
  end

  // ************************************************************
  // storage and datapath
  // ************************************************************
  // separate array: nothing here aliases legacy stack or packed-integer state
  logic [VEC_W-1:0]  vreg_reg [NUM_REGS];
  logic [CSR_W-1:0]  csr_reg;
  logic [CSR_W-1:0]  csr_next;
  logic [FLAG_W-1:0] ev_flags;
  logic [VEC_W-1:0]  wr_next;
  logic              wr_en;
  logic              take;
  lane_if            lp ();

  assign take = ce && op_valid;
  assign lp.op  = op;
  assign lp.a   = vreg_reg[dst_sel];
  assign lp.b   = vreg_reg[src_sel];
  assign lp.ftz = csr_reg[FTZ_BIT];

  lane_alu u_lanes (
    .lp (lp)
  );

  always_comb begin
    wr_en    = 1'b0;
    wr_next  = lp.a;
    ev_flags = '0;
    unique case (op)
      OP_LOAD_LO: begin
        wr_en   = 1'b1;
        wr_next = {lp.a[VEC_W-1:HALF_W], mem_rdata[HALF_W-1:0]};
      end
      OP_LOAD_HI: begin
        wr_en   = 1'b1;
        wr_next = {mem_rdata[HALF_W-1:0], lp.a[HALF_W-1:0]};
      end
      OP_LOAD_FULL: begin
        wr_en   = 1'b1;
        wr_next = mem_rdata;
      end
      OP_AND, OP_OR, OP_XOR, OP_ANDN, OP_MIN, OP_MAX, OP_MOV: begin
        wr_en    = 1'b1;
        wr_next  = lp.res;
        ev_flags = lp.flags;
      end
      default: wr_en = 1'b0;
    endcase
  end

  // no mode input: every execution mode sees the same file
  always_ff @(posedge clk) begin
    if (take && wr_en) begin
      vreg_reg[dst_sel] <= wr_next;
    end
  end

  // ************************************************************
  // control/status
  // ************************************************************
  always_comb begin
    csr_next = csr_reg;
    if (op == OP_CSR_LOAD) begin
      csr_next = csr_wdata & CSR_WMASK;
    end
    // a flag raised in the loading cycle survives the load
    csr_next[FLAG_LSB +: FLAG_W] = csr_next[FLAG_LSB +: FLAG_W] | ev_flags;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      csr_reg <= CSR_RESET;
    end else if (take) begin
      csr_reg <= csr_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      exc_req <= 1'b0;
    end else if (ce) begin
      // only events of this op whose mask bit is clear
      exc_req <= take && |(ev_flags & ~csr_reg[MASK_LSB +: MASK_W]);
    end
  end

  assign csr_value = csr_reg;

  // ************************************************************
  // stores, results and prefetch
  // ************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      st_valid <= 1'b0;
      st_wide  <= 1'b0;
      st_data  <= '0;
    end else if (ce) begin
      st_valid <= take && (op inside {OP_STORE_LO, OP_STORE_HI, OP_STORE_FULL});
      if (take) begin
        unique case (op)
          OP_STORE_LO: begin
            st_wide <= 1'b0;
            st_data <= {{HALF_W{1'b0}}, lp.b[HALF_W-1:0]};
          end
          OP_STORE_HI: begin
            st_wide <= 1'b0;
            st_data <= {{HALF_W{1'b0}}, lp.b[VEC_W-1:HALF_W]};
          end
          OP_STORE_FULL: begin
            st_wide <= 1'b1;
            st_data <= lp.b;
          end
          default: st_wide <= st_wide;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      result_data <= '0;
    end else if (take && wr_en) begin
      result_data <= wr_next;
    end
  end

  // address from the integer side only; block rounded to whole 32 bytes
  always_ff @(posedge clk) begin
    if (rst) begin
      pf_valid <= 1'b0;
      pf_addr  <= '0;
    end else if (ce) begin
      pf_valid <= take && (op == OP_PREFETCH);
      if (take && op == OP_PREFETCH) begin
        pf_addr <= {pf_addr_in[ADDR_W-1:PF_ALIGN_BITS], {PF_ALIGN_BITS{1'b0}}};
      end
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_csr_load;
    take && op == OP_CSR_LOAD;
  endsequence

  a_flags_sticky: assert property (@(posedge clk) disable iff (rst)
    !(take && op == OP_CSR_LOAD) |=> ((csr_reg[5:0] & $past(csr_reg[5:0])) == $past(csr_reg[5:0])))
    else $error("sticky flag fell without a load");

  a_load_zero_clr: assert property (@(posedge clk) disable iff (rst)
    s_csr_load ##0 (csr_wdata[5:0] == 6'h00 && ev_flags == 6'h00) |=> csr_reg[5:0] == 6'h00)
    else $error("flags not cleared by written zero");

  a_masks_reset: assert property (@(posedge clk)
    rst |=> csr_reg[12:7] == 6'h3F && csr_reg[5:0] == 6'h00)
    else $error("reset did not set masks and clear flags");

  a_masked_quiet: assert property (@(posedge clk) disable iff (rst)
    (ce && (ev_flags & ~csr_reg[12:7]) == 6'h00) |=> !exc_req)
    else $error("exception raised while masked");

  a_store_full: assert property (@(posedge clk) disable iff (rst)
    (take && op == OP_STORE_FULL) |=> st_valid && st_wide && st_data == $past(lp.b))
    else $error("full store data wrong");

  a_load_half: assert property (@(posedge clk) disable iff (rst)
    (take && op == OP_LOAD_LO) |=> result_data[127:64] == $past(lp.a[127:64])
      && result_data[63:0] == $past(mem_rdata[63:0]))
    else $error("half load disturbed upper lanes");

  a_lane_min: assert property (@(posedge clk) disable iff (rst)
    (take && op == OP_MIN && !is_nan(lp.a[31:0]) && !is_nan(lp.b[31:0]) && !lp.ftz
      && lp.a[31] == 1'b0 && lp.b[31] == 1'b0)
    |=> result_data[31:0] == (($past(lp.a[30:0]) < $past(lp.b[30:0]))
      ? $past(lp.a[31:0]) : $past(lp.b[31:0])))
    else $error("lane 0 minimum wrong");

  a_pf_align: assert property (@(posedge clk) disable iff (rst)
    (take && op == OP_PREFETCH) |=> pf_valid && pf_addr[4:0] == 5'h00
      && pf_addr[31:5] == $past(pf_addr_in[31:5]))
    else $error("prefetch block misaligned");

  a_ce_freeze: assert property (@(posedge clk) disable iff (rst)
    !ce |=> $stable(csr_reg) && $stable(st_valid) && $stable(pf_valid))
    else $error("state moved while clock enable low");

endmodule : vector_reg_file
`default_nettype wire

// ==== tb/mem_partner.sv ====
// Purpose: memory side of the vector file, feeds loads and takes stores
// Assumes: bench picks one slot per op
// Notes:   narrow stores touch the low 64 bits only
`timescale 1ns/100ps
`default_nettype none
module mem_partner
  import vec_pkg::*;
(
  input  wire logic             clk,
  input  wire logic [2:0]       slot,
  input  wire logic             st_valid,
  input  wire logic             st_wide,
  input  wire logic [VEC_W-1:0] st_data,
  output logic [VEC_W-1:0]      rdata
);
  logic [VEC_W-1:0] store [8];
  logic [2:0]       slot_q;
  assign rdata = store[slot];
  // store data comes one edge after its op; bench may move slot by then
  always @(posedge clk) begin
    slot_q <= slot;
    if (st_valid && st_wide) begin
      store[slot_q] <= st_data;
    end else if (st_valid) begin
      store[slot_q][63:0] <= st_data[63:0];
    end
  end
endmodule : mem_partner
`default_nettype wire

// ==== tb/vector_reg_file_bench.sv ====
// Purpose: self-checking bench of the packed single vector register file
// Assumes: one op every two cycles, outputs checked just after the taking edge
// Notes:   operands kept positive and below infinity so min/max compare as integers
`timescale 1ns/100ps
`default_nettype none
module vector_reg_file_bench;
  import vec_pkg::*;
  logic              clk;
  logic              rst;
  logic              ce;
  logic              op_valid;
  op_t               op;
  logic [SEL_W-1:0]  dst_sel;
  logic [SEL_W-1:0]  src_sel;
  logic [2:0]        slot;
  logic [VEC_W-1:0]  mem_rdata;
  logic [VEC_W-1:0]  result_data;
  logic [VEC_W-1:0]  st_data;
  logic [CSR_W-1:0]  csr_wdata;
  logic [CSR_W-1:0]  csr_value;
  logic [ADDR_W-1:0] pf_addr_in;
  logic [ADDR_W-1:0] pf_addr;
  logic              st_valid;
  logic              st_wide;
  logic              pf_valid;
  logic              exc_req;
  logic [31:0]       lfsr;
  logic [31:0]       rv;
  int                fail_count;
  int                total_checks;
  logic [VEC_W-1:0]  mr [8];
  logic [VEC_W-1:0]  e;
  op_t               lops [7];

  vector_reg_file #(.NUM_REGS(8)) dut (
    .clk(clk), .rst(rst), .ce(ce), .op_valid(op_valid), .op(op),
    .dst_sel(dst_sel), .src_sel(src_sel), .mem_rdata(mem_rdata),
    .csr_wdata(csr_wdata), .pf_addr_in(pf_addr_in), .result_data(result_data),
    .st_valid(st_valid), .st_wide(st_wide), .st_data(st_data),
    .pf_valid(pf_valid), .pf_addr(pf_addr), .csr_value(csr_value),
    .exc_req(exc_req));
  mem_partner pm (.clk(clk), .slot(slot), .st_valid(st_valid),
    .st_wide(st_wide), .st_data(st_data), .rdata(mem_rdata));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] rnd32();
    for (int i = 0; i < 32; i++) lfsr = {lfsr[30:0], lfsr[31]^lfsr[21]^lfsr[1]^lfsr[0]};
    return lfsr;
  endfunction : rnd32

  // positive normals only, never infinity or nan
  function automatic logic [127:0] rndv();
    return ({rnd32(), rnd32(), rnd32(), rnd32()} & {4{32'h3FFF_FFFF}}) | {4{32'h0080_0000}};
  endfunction : rndv

  function automatic logic [127:0] lane_op(op_t o, logic [127:0] a, logic [127:0] b);
    logic [127:0] r;
    for (int i = 0; i < 4; i++) begin
      logic [31:0] x;
      logic [31:0] y;
      x = a[32*i+:32];
      y = b[32*i+:32];
      case (o)
        OP_AND:  r[32*i+:32] = x & y;
        OP_OR:   r[32*i+:32] = x | y;
        OP_XOR:  r[32*i+:32] = x ^ y;
        OP_ANDN: r[32*i+:32] = ~x & y;
        OP_MIN:  r[32*i+:32] = (x < y) ? x : y;
        OP_MAX:  r[32*i+:32] = (x > y) ? x : y;
        default: r[32*i+:32] = y;
      endcase
    end
    return r;
  endfunction : lane_op

  task chk_v(input logic [127:0] got, input logic [127:0] exp, input string w);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: %s got %h exp %h", $time, w, got, exp);
    end
  endtask : chk_v

  task chk_w(input logic [31:0] got, input logic [31:0] exp, input string w);
    chk_v({96'h0, got}, {96'h0, exp}, w);
  endtask : chk_w

  task chk_b(input logic got, input logic exp, input string w);
    chk_v({127'h0, got}, {127'h0, exp}, w);
  endtask : chk_b

  task do_op(input op_t o, input logic [2:0] d, input logic [2:0] s);
    @(posedge clk);
    op <= o;
    dst_sel <= d;
    src_sel <= s;
    op_valid <= 1'b1;
    @(posedge clk);
    op_valid <= 1'b0;
    #1;
  endtask : do_op

  task print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (6000) @(posedge clk);
    fail_count++;
    $display("Error %0t: watchdog expired", $time);
    print_verdict();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    lfsr = 32'h3b1a;
    rst = 1'b1;
    ce = 1'b1;
    op_valid = 1'b0;
    op = OP_NOP;
    dst_sel = 3'd0;
    src_sel = 3'd0;
    slot = 3'd0;
    csr_wdata = 32'h0000_0000;
    pf_addr_in = 32'h0000_0000;
    lops = '{OP_AND, OP_OR, OP_XOR, OP_ANDN, OP_MOV, OP_MIN, OP_MAX};
    for (int i = 0; i < 8; i++) pm.store[i] = rndv();
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk_w(csr_value, 32'h0000_1F80, "csr reset");
    for (int i = 0; i < 8; i++) begin
      slot <= i[2:0];
      mr[i] = pm.store[i];
      do_op(OP_LOAD_FULL, i[2:0], 3'd0);
      chk_v(result_data, mr[i], "full load");
    end
    for (int i = 0; i < 8; i++) begin
      slot <= i[2:0];
      do_op(OP_STORE_FULL, 3'd0, 3'(i ^ 1));
      chk_v(st_data, mr[i ^ 1], "full store");
      chk_b(st_valid, 1'b1, "store pulse");
      chk_b(st_wide, 1'b1, "wide flag");
    end
    $display("test full transfers done");
    for (int i = 0; i < 8; i++) begin
      slot <= i[2:0];
      e = pm.store[i];
      do_op(OP_LOAD_LO, i[2:0], 3'd0);
      mr[i][63:0] = e[63:0];
      chk_v(result_data, mr[i], "low load");
      do_op(OP_LOAD_HI, i[2:0], 3'd0);
      mr[i][127:64] = e[63:0];
      chk_v(result_data, mr[i], "high load");
      do_op(OP_STORE_HI, 3'd0, i[2:0]);
      chk_v(st_data, {64'h0, mr[i][127:64]}, "high store");
      chk_b(st_wide, 1'b0, "narrow flag");
      do_op(OP_STORE_LO, 3'd0, i[2:0]);
      chk_v(st_data, {64'h0, mr[i][63:0]}, "low store");
      chk_b(st_valid, 1'b1, "low store pulse");
    end
    $display("test half transfers done");
    for (int k = 0; k < 28; k++) begin
      rv = rnd32();
      do_op(lops[k % 7], rv[2:0], rv[5:3]);
      mr[rv[2:0]] = lane_op(lops[k % 7], mr[rv[2:0]], mr[rv[5:3]]);
      chk_v(result_data, mr[rv[2:0]], "lane op");
      chk_b(exc_req, 1'b0, "masked event");
    end
    $display("test lane ops done");
    csr_wdata <= 32'hFFFF_FFFF;
    do_op(OP_CSR_LOAD, 3'd0, 3'd0);
    chk_w(csr_value, 32'h0000_FFBF, "csr all ones");
    slot <= 3'd0;
    pm.store[0] = {4{32'h0000_0001}};
    do_op(OP_LOAD_FULL, 3'd5, 3'd0);
    do_op(OP_MIN, 3'd5, 3'd5);
    chk_v(result_data, {VEC_W{1'b0}}, "flushed min");
    chk_b(exc_req, 1'b0, "masked flush");
    csr_wdata <= 32'h0000_0000;
    do_op(OP_CSR_LOAD, 3'd0, 3'd0);
    chk_w(csr_value, 32'h0000_0000, "flags cleared");
    slot <= 3'd0;
    e = rndv();
    pm.store[0] = e;
    mr[2] = e;
    do_op(OP_LOAD_FULL, 3'd2, 3'd0);
    e[31:0] = 32'h7FC0_0000;
    pm.store[0] = e;
    do_op(OP_LOAD_FULL, 3'd1, 3'd0);
    do_op(OP_MIN, 3'd1, 3'd2);
    chk_v(result_data, lane_op(OP_MIN, e, mr[2]), "nan min");
    chk_b(exc_req, 1'b1, "unmasked event");
    chk_w(csr_value, 32'h0000_0001, "invalid flag");
    do_op(OP_OR, 3'd3, 3'd4);
    chk_w(csr_value, 32'h0000_0001, "sticky flag");
    csr_wdata <= 32'h0000_1F80;
    do_op(OP_CSR_LOAD, 3'd0, 3'd0);
    do_op(OP_LOAD_FULL, 3'd1, 3'd0);
    do_op(OP_MIN, 3'd1, 3'd2);
    chk_b(exc_req, 1'b0, "masked nan");
    chk_w(csr_value, 32'h0000_1F81, "flag while masked");
    $display("test control status done");
    for (int k = 0; k < 4; k++) begin
      rv = rnd32();
      pf_addr_in <= rv;
      do_op(OP_PREFETCH, 3'd0, 3'd0);
      chk_b(pf_valid, 1'b1, "prefetch pulse");
      chk_w(pf_addr, rv & 32'hFFFF_FFE0, "prefetch block");
    end
    $display("test prefetch done");
    ce <= 1'b0;
    csr_wdata <= 32'h0000_0000;
    do_op(OP_CSR_LOAD, 3'd0, 3'd0);
    chk_b(pf_valid, 1'b1, "pulse held");
    chk_w(csr_value, 32'h0000_1F81, "frozen csr");
    ce <= 1'b1;
    @(posedge clk);
    #1;
    chk_b(pf_valid, 1'b0, "pulse ends");
    $display("test clock enable done");
    print_verdict();
  end
endmodule : vector_reg_file_bench
`default_nettype wire
